// ===== hw/sbc_pkg.sv
// Purpose: Shared constants and types for the mode controller and its SPI
// Assumes: 25 MHz system clock, 16-bit frames, 3-bit register address
// Notes:   Field positions and reset values live here, except the status read bits and the wmc_r reset, set in sbc_dev
package sbc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Frame layout
  localparam int          FRAME_BITS  = 16;
  localparam int          FRM_ADDR_HI = 15;
  localparam int          FRM_ADDR_LO = 13;
  localparam int          FRM_RO      = 12;
  localparam int          DATA_BITS   = 12;

  // Register addresses
  localparam logic [2:0]  ADDR_WDS    = 3'h0;
  localparam logic [2:0]  ADDR_MC     = 3'h1;
  localparam logic [2:0]  ADDR_ICTL   = 3'h2;
  localparam logic [2:0]  ADDR_ISTAT  = 3'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog and status fields
  localparam int          WDS_WMC     = 11;
  localparam int          WDS_NWP_HI  = 10;
  localparam int          WDS_NWP_LO  = 8;
  localparam int          WDS_WOS     = 7;
  localparam logic [2:0]  NWP_RST     = 3'h4;

  // Mode control fields
  localparam int          MC_SEL_HI   = 11;
  localparam int          MC_SEL_LO   = 10;
  localparam int          MC_LHC      = 8;
  localparam int          MC_RSVD     = 6;
  localparam logic [11:0] MC_RST      = 12'h200;
  localparam logic [1:0]  MC_STANDBY  = 2'h0;
  localparam logic [1:0]  MC_SLEEP    = 2'h1;
  localparam logic [1:0]  MC_NORM_V2OFF = 2'h2;
  localparam logic [1:0]  MC_NORM_V2ON  = 2'h3;

  // Interrupt control fields
  localparam int          ICTL_LP     = 11;
  localparam logic [11:0] ICTL_RST    = 12'h000;
  localparam logic [11:0] ISTAT_RST   = 12'h000;

  // Watchdog operating modes
  localparam logic [1:0]  WDM_OFF     = 2'h0;
  localparam logic [1:0]  WDM_TIMEOUT = 2'h1;
  localparam logic [1:0]  WDM_WINDOW  = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int          CLK_PERIOD_NS = 40;
  localparam int          SHORT_RST_NS  = 3600000;
  localparam int          SHORT_RST_CYC =
    (SHORT_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          RST_CNT_W     = 17;
  localparam int          HOST_HALF_CYC = 16;

  ////////////////////////////////////////////////////////////////////////////
  // State types
  typedef enum logic [3:0] {
    ST_STANDBY  = 4'b0001,
    ST_NORMAL   = 4'b0010,
    ST_SLEEP    = 4'b0100,
    ST_OVERTEMP = 4'b1000
  } sbc_mode_t;

  typedef enum logic [4:0] {
    HS_IDLE  = 5'b00001,
    HS_LEAD  = 5'b00010,
    HS_HIGH  = 5'b00100,
    HS_LOW   = 5'b01000,
    HS_TRAIL = 5'b10000
  } sbc_hst_t;

endpackage

// ===== hw/sbc_spi_if.sv
// Purpose: SPI link between the mode controller and its master
// Assumes: Data-out wire is driven straight from the device; its enable only feeds the checker
// Notes:   No clocking block; plain nets only
interface sbc_spi_if;
  logic spi_select_n;
  logic spi_clk;
  logic serial_data_in;
  logic serial_data_out;
  logic serial_data_out_oe;

  modport dev (
    input  spi_select_n,
    input  spi_clk,
    input  serial_data_in,
    output serial_data_out,
    output serial_data_out_oe
  );

  modport host (
    output spi_select_n,
    output spi_clk,
    output serial_data_in,
    input  serial_data_out
  );
endinterface

// ===== hw/sbc_sync3.sv
// Purpose: Three-stage synchroniser with agreement filter
// Assumes: Inputs come from outside the clk_sys domain
// Notes:   Output moves only once stages two and three agree
module sbc_sync3 #(
  parameter int W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         resetn,
  input  wire logic [W-1:0] d,
  input  wire logic [W-1:0] rst_val,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] q_r;
  logic [W-1:0] q_nxt;
  logic [1:0]   fill_r;
  logic [1:0]   fill_nxt;

  // Stages hold no pin value until three edges after release, so the
  // reset value stands in until then; avoids a false edge after reset
  always_comb begin
    fill_nxt = (fill_r == 2'h3) ? fill_r : fill_r + 2'h1;
    for (int i = 0; i < W; i++) begin
      q_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : q_r[i];
    end
    if (fill_r != 2'h3) begin
      q_nxt = rst_val;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s1_r   <= '0;
      s2_r   <= '0;
      s3_r   <= '0;
      q_r    <= '0;
      fill_r <= 2'h0;
    end else begin
      s1_r   <= d;
      s2_r   <= s1_r;
      s3_r   <= s2_r;
      fill_r <= fill_nxt;
      q_r    <= q_nxt;
    end
  end

  assign q = (fill_r == 2'h0) ? rst_val : q_r;
endmodule

// ===== hw/sbc_dev.sv
// Purpose: Operating-mode controller with SPI register slave
// Assumes: SPI pins and detector levels are asynchronous to clk_sys
// Notes:   Link clock is sampled, not used as a clock
module sbc_dev
  import sbc_pkg::*;
#(
  parameter int RST_CYC = sbc_pkg::SHORT_RST_CYC
) (
  input  wire logic                 clk_sys,
  input  wire logic                 resetn,
  sbc_spi_if.dev                    spi,
  input  wire logic                 overtemp_detect,
  input  wire logic                 can_wake_event,
  input  wire logic                 local_wake_event,
  input  wire logic                 wake_input1_level,
  input  wire logic                 wake_input2_level,
  input  wire logic                 wdog_disable_pin,
  input  wire logic                 main_regulator_uv,
  input  wire logic                 can_regulator_uv,
  input  wire logic                 interrupt_out_n,
  input  wire logic                 wake_pending,
  input  wire logic                 can_wake_en,
  input  wire logic                 local_wake_en,
  input  wire logic                 reset_line_n_in,
  output logic                      reset_line_n_out,
  output logic                      reset_line_n_oe,
  output logic                      fallback_out,
  output logic                      fallback_out_oe,
  output logic                      main_regulator_en,
  output logic                      can_regulator_en,
  output logic                      can_active,
  output logic                      can_lowpower,
  output logic [1:0]                wdog_mode,
  output logic [2:0]                wdog_period_sel,
  output sbc_pkg::sbc_mode_t        mode_state,
  output logic [sbc_pkg::DATA_BITS-1:0] int_control
);
  import sbc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  localparam int NS = 13;
  logic [NS-1:0] raw;
  logic [NS-1:0] syn;
  logic          cs_n_s, sck_s, sdi_s, otp_s, cwk_s, lwk_s, wl1_s, wl2_s;
  logic          wdog_disable_pin_s, v1uv_s, v2uv_s, interrupt_out_n_s, wkp_s, rstin_s;

  assign raw = {spi.spi_select_n, spi.spi_clk, spi.serial_data_in,
                overtemp_detect, can_wake_event, local_wake_event,
                wake_input1_level, wake_input2_level, wdog_disable_pin,
                main_regulator_uv, can_regulator_uv, interrupt_out_n,
                reset_line_n_in};
  assign {cs_n_s, sck_s, sdi_s, otp_s, cwk_s, lwk_s, wl1_s, wl2_s,
          wdog_disable_pin_s, v1uv_s, v2uv_s, interrupt_out_n_s, rstin_s} = syn;

  sbc_sync3 #(.W(NS)) u_sync (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .d       (raw),
    .rst_val (13'h1003),                    // Select, interrupt, reset idle high
    .q       (syn)
  );

  // Wake pending comes from on-chip logic, no sync needed
  assign wkp_s = wake_pending;

  ////////////////////////////////////////////////////////////////////////////
  // Register contents
  logic                 wmc_r, wmc_nxt;
  logic [2:0]           nwp_r, nwp_nxt;
  logic [DATA_BITS-1:0] mc_r, mc_nxt, ictl_r, ictl_nxt, istat_r, istat_nxt;
  logic [DATA_BITS-1:0] status_word;

  assign status_word = {wmc_r, nwp_r, wdog_disable_pin_s, v1uv_s, v2uv_s,
                        wl1_s, wl2_s, 3'h0};

  function automatic logic [DATA_BITS-1:0] rd_reg(input logic [2:0] a);
    case (a)
      ADDR_WDS:   rd_reg = status_word;
      ADDR_MC:    rd_reg = mc_r;
      ADDR_ICTL:  rd_reg = ictl_r;
      ADDR_ISTAT: rd_reg = istat_r;
      default:    rd_reg = '0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // SPI slave: edges found on the sampled link clock
  logic        sck_q_r, cs_q_r;
  logic [15:0] rx_r, rx_nxt, tx_r, tx_nxt;
  logic [4:0]  fcnt_r, fcnt_nxt, rcnt_r, rcnt_nxt;
  logic        sdo_r, sdo_nxt, sdo_oe_r, sdo_oe_nxt;
  logic        wr_r, wr_nxt;
  logic [2:0]  wa_r, wa_nxt;
  logic [DATA_BITS-1:0] wd_r, wd_nxt;
  logic        rise, fall;

  assign rise = sck_s & ~sck_q_r;
  assign fall = ~sck_s & sck_q_r;

  always_comb begin
    rx_nxt     = rx_r;
    tx_nxt     = tx_r;
    fcnt_nxt   = fcnt_r;
    rcnt_nxt   = rcnt_r;
    sdo_nxt    = sdo_r;
    sdo_oe_nxt = ~cs_n_s;
    wr_nxt     = 1'b0;
    wa_nxt     = wa_r;
    wd_nxt     = wd_r;
    if (cs_n_s) begin
      fcnt_nxt = '0;
      rcnt_nxt = '0;
      tx_nxt   = {ADDR_WDS, 1'b0, status_word};
      sdo_nxt  = tx_nxt[15];
      // Commit only on select release after exactly 16 samples
      if (!cs_q_r && fcnt_r == 5'(FRAME_BITS) &&
          !rx_r[FRM_RO]) begin
        wr_nxt = 1'b1;
        wa_nxt = rx_r[FRM_ADDR_HI:FRM_ADDR_LO];
        wd_nxt = rx_r[DATA_BITS-1:0];
      end
    end else begin
      if (fall) begin
        rx_nxt = {rx_r[14:0], sdi_s};
        if (fcnt_r <= 5'(FRAME_BITS)) begin
          fcnt_nxt = fcnt_r + 5'h1;
        end
        // Address is known after the third sample
        if (fcnt_r == 5'h2) begin
          tx_nxt[12:0] = {1'b0, rd_reg({rx_r[1:0], sdi_s})};
        end
      end
      if (rise && rcnt_r < 5'(FRAME_BITS)) begin
        sdo_nxt  = tx_r[4'hf - rcnt_r[3:0]];
        rcnt_nxt = rcnt_r + 5'h1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sck_q_r  <= 1'b0;
      cs_q_r   <= 1'b1;
      rx_r     <= '0;
      tx_r     <= '0;
      fcnt_r   <= '0;
      rcnt_r   <= '0;
      sdo_r    <= 1'b0;
      sdo_oe_r <= 1'b0;
      wr_r     <= 1'b0;
      wa_r     <= '0;
      wd_r     <= '0;
    end else begin
      sck_q_r  <= sck_s;
      cs_q_r   <= cs_n_s;
      rx_r     <= rx_nxt;
      tx_r     <= tx_nxt;
      fcnt_r   <= fcnt_nxt;
      rcnt_r   <= rcnt_nxt;
      sdo_r    <= sdo_nxt;
      sdo_oe_r <= sdo_oe_nxt;
      wr_r     <= wr_nxt;
      wa_r     <= wa_nxt;
      wd_r     <= wd_nxt;
    end
  end

  assign spi.serial_data_out    = sdo_r;
  assign spi.serial_data_out_oe = sdo_oe_r;

  ////////////////////////////////////////////////////////////////////////////
  // Mode state machine, registers and reset pulse
  sbc_mode_t            st_r, st_nxt;
  logic [RST_CNT_W-1:0] rstc_r, rstc_nxt;
  logic                 start_rst, sys_rst, sleep_ok, wr_mc;
  logic                 rdrv_r, rdrv_nxt, fb_r, fb_nxt, v1_r, v1_nxt;
  logic                 v2_r, v2_nxt, ca_r, ca_nxt, clp_r, clp_nxt;
  logic [1:0]           wdm_r, wdm_nxt, new_sel;

  assign sys_rst  = (rstc_r != '0) | ~rstin_s;
  assign sleep_ok = interrupt_out_n_s & ~wkp_s &
                    (can_wake_en | local_wake_en);
  assign wr_mc    = wr_r && wa_r == ADDR_MC;
  assign new_sel  = wd_r[MC_SEL_HI:MC_SEL_LO];

  always_comb begin
    st_nxt    = st_r;
    wmc_nxt   = wmc_r;
    nwp_nxt   = nwp_r;
    mc_nxt    = mc_r;
    ictl_nxt  = ictl_r;
    istat_nxt = istat_r;
    start_rst = 1'b0;
    rstc_nxt  = (rstc_r != '0) ? rstc_r - 1'b1 : rstc_r;
    if (wr_r) begin
      case (wa_r)
        ADDR_WDS: begin
          wmc_nxt   = wd_r[WDS_WMC];
          nwp_nxt   = wd_r[WDS_NWP_HI:WDS_NWP_LO];
          start_rst = wd_r[WDS_WOS];
        end
        ADDR_MC: begin
          mc_nxt          = wd_r;
          mc_nxt[MC_RSVD] = 1'b0;
        end
        ADDR_ICTL:  ictl_nxt  = wd_r;
        ADDR_ISTAT: istat_nxt = wd_r;
        default: ;
      endcase
    end
    case (st_r)
      ST_STANDBY, ST_NORMAL: begin
        if (otp_s) begin
          st_nxt         = ST_OVERTEMP;
          mc_nxt[MC_LHC] = 1'b1;
        end else if (st_r == ST_NORMAL && sys_rst) begin
          st_nxt                   = ST_STANDBY;
          mc_nxt[MC_SEL_HI:MC_SEL_LO] = MC_STANDBY;
        end else if (wr_mc && new_sel == MC_SLEEP) begin
          if (sleep_ok) begin
            st_nxt = ST_SLEEP;
          end else begin
            start_rst = 1'b1;
          end
        end else if (wr_mc && new_sel[1]) begin
          st_nxt = ST_NORMAL;
        end else if (wr_mc && new_sel == MC_STANDBY) begin
          st_nxt = ST_STANDBY;
        end
      end
      ST_SLEEP: begin
        if (cwk_s || lwk_s) begin
          st_nxt                      = ST_STANDBY;
          mc_nxt[MC_SEL_HI:MC_SEL_LO] = MC_STANDBY;
          start_rst                   = 1'b1;
        end
      end
      ST_OVERTEMP: begin
        if (!otp_s) begin
          st_nxt    = ST_STANDBY;
          start_rst = 1'b1;
        end
      end
      default: st_nxt = ST_STANDBY;
    endcase
    if (start_rst) begin
      rstc_nxt = RST_CNT_W'(RST_CYC);
    end
    if (start_rst || sys_rst) begin
      nwp_nxt = NWP_RST;
    end
    // Outputs follow the current mode one cycle later
    v1_nxt   = st_r == ST_STANDBY || st_r == ST_NORMAL;
    v2_nxt   = st_r == ST_NORMAL &&
               mc_r[MC_SEL_HI:MC_SEL_LO] == MC_NORM_V2ON;
    ca_nxt   = st_r == ST_NORMAL && !ictl_r[ICTL_LP];
    clp_nxt  = st_r != ST_OVERTEMP && ictl_r[ICTL_LP];
    rdrv_nxt = rstc_r != '0 || st_r == ST_SLEEP ||
               st_r == ST_OVERTEMP;
    fb_nxt   = mc_r[MC_LHC];
    if (wdog_disable_pin_s || st_r == ST_SLEEP || st_r == ST_OVERTEMP) begin
      wdm_nxt = WDM_OFF;
    end else if (st_r == ST_NORMAL) begin
      wdm_nxt = wmc_r ? WDM_TIMEOUT : WDM_WINDOW;
    end else begin
      wdm_nxt = wmc_r ? WDM_OFF : WDM_TIMEOUT;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st_r    <= ST_STANDBY;
      wmc_r   <= 1'b0;
      nwp_r   <= NWP_RST;
      mc_r    <= MC_RST;
      ictl_r  <= ICTL_RST;
      istat_r <= ISTAT_RST;
      rstc_r  <= '0;
      rdrv_r  <= 1'b1;
      fb_r    <= 1'b0;
      v1_r    <= 1'b0;
      v2_r    <= 1'b0;
      ca_r    <= 1'b0;
      clp_r   <= 1'b0;
      wdm_r   <= WDM_OFF;
    end else begin
      st_r    <= st_nxt;
      wmc_r   <= wmc_nxt;
      nwp_r   <= nwp_nxt;
      mc_r    <= mc_nxt;
      ictl_r  <= ictl_nxt;
      istat_r <= istat_nxt;
      rstc_r  <= rstc_nxt;
      rdrv_r  <= rdrv_nxt;
      fb_r    <= fb_nxt;
      v1_r    <= v1_nxt;
      v2_r    <= v2_nxt;
      ca_r    <= ca_nxt;
      clp_r   <= clp_nxt;
      wdm_r   <= wdm_nxt;
    end
  end

  // Open-drain pins: only ever pulled low
  assign reset_line_n_out  = 1'b0;
  assign reset_line_n_oe   = rdrv_r;
  assign fallback_out      = 1'b0;
  assign fallback_out_oe   = fb_r;
  assign main_regulator_en = v1_r;
  assign can_regulator_en  = v2_r;
  assign can_active        = ca_r;
  assign can_lowpower      = clp_r;
  assign wdog_mode         = wdm_r;
  assign wdog_period_sel   = nwp_r;
  assign mode_state        = st_r;
  assign int_control       = ictl_r;
endmodule

// ===== hw/sbc_host.sv
// Purpose: SPI master end that issues one 16-bit frame per request
// Assumes: Link clock made here by dividing clk_sys
// Notes:   Half period must cover both synchroniser delays
module sbc_host
  import sbc_pkg::*;
#(
  parameter int HALF_CYC = sbc_pkg::HOST_HALF_CYC
) (
  input  wire logic                     clk_sys,
  input  wire logic                     resetn,
  sbc_spi_if.host                       spi,
  input  wire logic                     req_valid,
  input  wire logic [2:0]               req_addr,
  input  wire logic                     req_ro,
  input  wire logic [sbc_pkg::DATA_BITS-1:0] req_data,
  output logic                          req_ready,
  output logic                          rsp_valid,
  output logic [sbc_pkg::FRAME_BITS-1:0] rsp_data
);
  import sbc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic        sdo_s;
  sbc_hst_t    st_r, st_nxt;
  logic [15:0] tmr_r, tmr_nxt, tx_r, tx_nxt, rx_r, rx_nxt, rd_r, rd_nxt;
  logic [4:0]  bit_r, bit_nxt;
  logic        cs_n_r, cs_n_nxt, sck_r, sck_nxt, sdi_r, sdi_nxt;
  logic        rdy_r, rdy_nxt, rv_r, rv_nxt;

  sbc_sync3 #(.W(1)) u_sync (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .d       (spi.serial_data_out),
    .rst_val (1'b0),
    .q       (sdo_s)
  );

  always_comb begin
    st_nxt   = st_r;
    tmr_nxt  = (tmr_r != '0) ? tmr_r - 16'h1 : tmr_r;
    tx_nxt   = tx_r;
    rx_nxt   = rx_r;
    rd_nxt   = rd_r;
    bit_nxt  = bit_r;
    cs_n_nxt = cs_n_r;
    sck_nxt  = sck_r;
    sdi_nxt  = sdi_r;
    rdy_nxt  = rdy_r;
    rv_nxt   = 1'b0;
    case (st_r)
      HS_IDLE: begin
        if (req_valid && rdy_r) begin
          tx_nxt   = {req_addr, req_ro, req_data};
          cs_n_nxt = 1'b0;
          rdy_nxt  = 1'b0;
          bit_nxt  = '0;
          tmr_nxt  = 16'(HALF_CYC - 1);
          st_nxt   = HS_LEAD;
        end else if (!rdy_r) begin
          // Ready first rises one edge after reset is released
          rdy_nxt = 1'b1;
        end
      end
      HS_LEAD, HS_LOW: begin
        if (tmr_r == '0) begin
          tmr_nxt = 16'(HALF_CYC - 1);
          if (bit_r == 5'(FRAME_BITS)) begin
            cs_n_nxt = 1'b1;
            tmr_nxt  = 16'(2 * HALF_CYC - 1);
            st_nxt   = HS_TRAIL;
          end else begin
            sck_nxt = 1'b1;
            sdi_nxt = tx_r[15];
            tx_nxt  = {tx_r[14:0], 1'b0};
            st_nxt  = HS_HIGH;
          end
        end
      end
      HS_HIGH: begin
        if (tmr_r == '0) begin
          rx_nxt  = {rx_r[14:0], sdo_s};
          sck_nxt = 1'b0;
          bit_nxt = bit_r + 5'h1;
          tmr_nxt = 16'(HALF_CYC - 1);
          st_nxt  = HS_LOW;
        end
      end
      HS_TRAIL: begin
        // Gap lets the far end see select high before the next frame
        if (tmr_r == '0) begin
          rv_nxt  = 1'b1;
          rd_nxt  = rx_r;
          rdy_nxt = 1'b1;
          st_nxt  = HS_IDLE;
        end
      end
      default: st_nxt = HS_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st_r   <= HS_IDLE;
      tmr_r  <= '0;
      tx_r   <= '0;
      rx_r   <= '0;
      rd_r   <= '0;
      bit_r  <= '0;
      cs_n_r <= 1'b1;
      sck_r  <= 1'b0;
      sdi_r  <= 1'b0;
      rdy_r  <= 1'b0;
      rv_r   <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      tmr_r  <= tmr_nxt;
      tx_r   <= tx_nxt;
      rx_r   <= rx_nxt;
      rd_r   <= rd_nxt;
      bit_r  <= bit_nxt;
      cs_n_r <= cs_n_nxt;
      sck_r  <= sck_nxt;
      sdi_r  <= sdi_nxt;
      rdy_r  <= rdy_nxt;
      rv_r   <= rv_nxt;
    end
  end

  assign spi.spi_select_n   = cs_n_r;
  assign spi.spi_clk        = sck_r;
  assign spi.serial_data_in = sdi_r;
  assign req_ready          = rdy_r;
  assign rsp_valid          = rv_r;
  assign rsp_data           = rd_r;
endmodule

// ===== sim/sbc_chk.sv
// Purpose: Wire checks on the mode controller link
// Assumes: Link lines sampled by clk_sys
// Notes:   Counts falling link-clock edges in each frame
module sbc_chk (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic spi_select_n,
  input wire logic spi_clk,
  input wire logic serial_data_in,
  input wire logic serial_data_out,
  input wire logic serial_data_out_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] fl_r, fl_nxt;
  logic       ck_r, ck_nxt;
  always_comb begin
    ck_nxt = spi_clk;
    fl_nxt = fl_r;
    if (spi_select_n) fl_nxt = 5'h0;
    else if (ck_r && !spi_clk) fl_nxt = fl_r + 5'h1;
  end
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      fl_r <= 5'h0;
      ck_r <= 1'b0;
    end else begin
      fl_r <= fl_nxt;
      ck_r <= ck_nxt;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  sequence s_start; $fell(spi_select_n); endsequence
  sequence s_end; $rose(spi_select_n); endsequence
  a_idle_clk_low: assert property (
    spi_select_n |-> !spi_clk)
    else $error("clock high while idle");
  a_out_floats: assert property (
    spi_select_n [*8] |-> !serial_data_out_oe)
    else $error("output driven while deselected");
  a_out_drives: assert property (
    s_start |-> ##[1:8] serial_data_out_oe)
    else $error("output not driven in frame");
  a_in_holds: assert property (
    $fell(spi_clk) |-> $stable(serial_data_in))
    else $error("input moved at sample edge");
  a_out_holds: assert property (
    $fell(spi_clk) && serial_data_out_oe |-> $stable(serial_data_out))
    else $error("output moved at sample edge");
  a_frame_len: assert property (
    s_end |-> fl_r == 5'h10)
    else $error("frame not 16 bits");
  a_head_zero: assert property (
    $fell(spi_clk) && fl_r < 5'h4 |-> !serial_data_out)
    else $error("reply header not zero");
  a_select_gap: assert property (
    s_end |=> spi_select_n [*7])
    else $error("frames too close");
endmodule

// ===== sim/test_sbc_mode_control_spi_regs.sv
// Purpose: Both link ends driven through the host request port
// Assumes: Short reset pulse shortened to 60 cycles
// Notes:   Reset line resolved from the device's pull-down
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin \
  fail_count++; $display("MISMATCH %0t bad value", $time); end end
module test_sbc_mode_control_spi_regs;
  timeunit 1ns;
  timeprecision 1ns;
  import sbc_pkg::*;
  logic clk_sys = 0, resetn = 0, req_valid = 0, req_ro = 0, ext_rst_n = 1;
  logic [2:0] req_addr = 0;
  logic [11:0] req_data = 0, int_control;
  logic overtemp_detect = 0, can_wake_event = 0, wake_input1_level = 0;
  logic wdog_disable_pin = 0, main_regulator_uv = 0, interrupt_out_n = 1;
  logic local_wake_event = 0, wake_pending = 0, local_wake_en = 0;
  logic can_wake_en = 0, reset_line_n_in, reset_line_n_oe, fallback_out_oe;
  logic main_regulator_en, can_regulator_en, can_active, can_lowpower;
  logic req_ready, rsp_valid;
  logic [1:0] wdog_mode;
  logic [2:0] wdog_period_sel;
  logic [15:0] rsp_data, r;
  sbc_mode_t mode_state;
  int fail_count = 0, n_tests = 0;
  // Pull-down from the device wins over the external level
  assign reset_line_n_in = ext_rst_n & ~reset_line_n_oe;
  always #20 clk_sys = ~clk_sys;
  sbc_spi_if sbc_spi_if_i ();
  sbc_host #(.HALF_CYC(16)) sbc_host_i (.clk_sys, .resetn,
    .spi(sbc_spi_if_i), .req_valid, .req_addr, .req_ro, .req_data,
    .req_ready, .rsp_valid, .rsp_data);
  sbc_dev #(.RST_CYC(60)) sbc_dev_i (.clk_sys, .resetn, .spi(sbc_spi_if_i),
    .overtemp_detect, .can_wake_event, .local_wake_event,
    .wake_input1_level, .wake_input2_level(1'b0), .wdog_disable_pin,
    .main_regulator_uv, .can_regulator_uv(1'b0), .interrupt_out_n,
    .wake_pending, .can_wake_en, .local_wake_en,
    .reset_line_n_in, .reset_line_n_out(), .reset_line_n_oe,
    .fallback_out(), .fallback_out_oe, .main_regulator_en,
    .can_regulator_en, .can_active, .can_lowpower, .wdog_mode,
    .wdog_period_sel, .mode_state, .int_control);
  sbc_chk sbc_chk_i (.clk_sys, .resetn,
    .spi_select_n(sbc_spi_if_i.spi_select_n),
    .spi_clk(sbc_spi_if_i.spi_clk),
    .serial_data_in(sbc_spi_if_i.serial_data_in),
    .serial_data_out(sbc_spi_if_i.serial_data_out),
    .serial_data_out_oe(sbc_spi_if_i.serial_data_out_oe));
  //////////////////////////////////////////////////////////////////////////////
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic xfer(input logic [2:0] a, input logic ro,
                      input logic [11:0] d);
    int n;
    @(posedge clk_sys);
    #1;
    {req_addr, req_ro, req_data} = {a, ro, d};
    req_valid = 1'b1;
    n = 0;
    while (req_ready !== 1'b1 && n < 50) begin @(negedge clk_sys); n++; end
    @(posedge clk_sys);
    #1;
    req_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 1000) begin @(negedge clk_sys); n++; end
    `CHK(n < 1000, 1'b1)
    r = rsp_data;
    wt(4);
  endtask
  task automatic t_reset;
    xfer(ADDR_WDS, 1'b1, 12'h000);
    `CHK(r[15:12], 4'h0)
    `CHK(r[10:8], NWP_RST)
    `CHK(r[2:0], 3'h0)
    `CHK(wdog_mode, WDM_TIMEOUT)
    xfer(ADDR_MC, 1'b1, 12'h000);
    `CHK(r[11:10], MC_STANDBY)
  endtask
  task automatic t_normal;
    xfer(ADDR_MC, 1'b0, 12'he00);
    `CHK(mode_state, ST_NORMAL)
    `CHK(can_regulator_en, 1'b1)
    `CHK(can_active, 1'b1)
    `CHK(wdog_mode, WDM_WINDOW)
    xfer(ADDR_ICTL, 1'b0, 12'h800);
    `CHK({can_active, can_lowpower}, 2'h1)
    xfer(ADDR_ICTL, 1'b1, 12'h000);
    `CHK(r[11:0], 12'h800)
    `CHK(int_control, 12'h800)
    xfer(ADDR_MC, 1'b1, 12'h200);
    `CHK(mode_state, ST_NORMAL)
    `CHK(r[11:10], MC_NORM_V2ON)
    xfer(ADDR_MC, 1'b0, 12'h200);
    `CHK(mode_state, ST_STANDBY)
    xfer(ADDR_MC, 1'b0, 12'ha00);
    `CHK(mode_state, ST_NORMAL)
    `CHK(can_regulator_en, 1'b0)
    ext_rst_n = 1'b0;
    wt(8);
    ext_rst_n = 1'b1;
    wt(8);
    `CHK(mode_state, ST_STANDBY)
  endtask
  task automatic no_sleep;
    xfer(ADDR_MC, 1'b0, 12'h600);
    `CHK(mode_state, ST_STANDBY)
    `CHK(reset_line_n_oe, 1'b1)
    wt(80);
    `CHK(reset_line_n_oe, 1'b0)
  endtask
  task automatic t_sleep;
    {interrupt_out_n, can_wake_en} = 2'h1;
    wt(8);
    no_sleep;
    {interrupt_out_n, wake_pending} = 2'h3;
    no_sleep;
    {wake_pending, can_wake_en} = 2'h0;
    no_sleep;
    can_wake_en = 1'b1;
    xfer(ADDR_MC, 1'b0, 12'h600);
    `CHK(mode_state, ST_SLEEP)
    `CHK({main_regulator_en, reset_line_n_oe}, 2'h1)
    can_wake_event = 1'b1;
    wt(10);
    can_wake_event = 1'b0;
    `CHK({mode_state, main_regulator_en}, {ST_STANDBY, 1'b1})
    wt(80);
    xfer(ADDR_MC, 1'b1, 12'h000);
    `CHK(r[11:10], MC_STANDBY)
    {can_wake_en, local_wake_en} = 2'h1;
    xfer(ADDR_MC, 1'b0, 12'h600);
    `CHK(mode_state, ST_SLEEP)
    local_wake_event = 1'b1;
    wt(10);
    local_wake_event = 1'b0;
    `CHK(mode_state, ST_STANDBY)
    `CHK(reset_line_n_oe, 1'b1)
    wt(80);
  endtask
  task automatic t_hot;
    overtemp_detect = 1'b1;
    wt(10);
    `CHK(mode_state, ST_OVERTEMP)
    `CHK({fallback_out_oe, reset_line_n_oe}, 2'h3)
    `CHK(main_regulator_en, 1'b0)
    `CHK({can_active, can_lowpower}, 2'h0)
    overtemp_detect = 1'b0;
    wt(10);
    `CHK(mode_state, ST_STANDBY)
    `CHK(reset_line_n_oe, 1'b1)
    wt(80);
  endtask
  task automatic t_status;
    {wdog_disable_pin, main_regulator_uv, wake_input1_level} = 3'h7;
    wt(8);
    `CHK(wdog_mode, WDM_OFF)
    xfer(ADDR_WDS, 1'b0, 12'h200);
    `CHK(wdog_period_sel, 3'h2)
    xfer(ADDR_WDS, 1'b1, 12'h000);
    `CHK(r[11:0], 12'h2d0)
    xfer(ADDR_ISTAT, 1'b0, 12'h5a5);
    xfer(ADDR_ISTAT, 1'b1, 12'h000);
    `CHK(r[11:0], 12'h5a5)
    xfer(3'h4, 1'b0, 12'hfff);
    `CHK(r, 16'h0000)
    `CHK(reset_line_n_oe, 1'b0)
    xfer(ADDR_WDS, 1'b0, 12'h080);
    `CHK(reset_line_n_oe, 1'b1)
    xfer(ADDR_WDS, 1'b1, 12'h000);
    `CHK(r[10:8], NWP_RST)
  endtask
  task automatic stop_test;
    if (fail_count == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    wt(20);
    resetn = 1'b1;
    wt(100);
    t_reset;
    t_normal;
    t_sleep;
    t_hot;
    t_status;
    stop_test;
  end
  initial begin
    #2000000;
    fail_count++;
    stop_test;
  end
endmodule
